/* File: include/queue_cmd_regs.vh */
/*
 * register offsets, field positions, reset value and vector codes of the
 * global command register and its queue set-up engine.
 * assumes it is included by bare name from the design files.
 */
`ifndef QUEUE_CMD_REGS_VH
`define QUEUE_CMD_REGS_VH

// register offset inside the global register space
`define GCMD_OFFSET 8'h00
// reset value: request result mask set, all else clear
`define GCMD_RESET 32'h0000_0200

// field positions
`define GCMD_RXQ_MSB 31
`define GCMD_RXQ_LSB 28
`define GCMD_TXQ_MSB 27
`define GCMD_TXQ_LSB 24
`define GCMD_CFGQ_BIT 21
`define GCMD_PERQ_BIT 20
`define GCMD_REPOLL_MSB 13
`define GCMD_REPOLL_LSB 10
`define GCMD_MASK_BIT 9
`define GCMD_ACTION_BIT 0

// queue numbering: rx 0..3, tx 4..7, config 8, peripheral 9
`define QID_RX0 4'h0
`define QID_TX0 4'h4
`define QID_CFG 4'h8
`define QID_PER 4'h9
`define NUM_QUEUES 10

// result vector codes written into the config queue (arbitrary values)
`define VEC_ACTION_ACK 32'hA000_0001
`define VEC_ACTION_FAIL 32'hA000_0002

`endif

/* File: hdl/queue_param_store.v */
/*
 * small memory holding base address and length of each interrupt queue.
 * assumes one writer (the set-up engine) and one reader (the vector
 * router), both on sys_clk; read data come out of a register.
 */
`timescale 1ns/10ps
module queue_param_store #(
    parameter DEPTH = 10,
    parameter IDX_W = 4,
    parameter ADDR_W = 32,
    parameter LEN_W = 12
) (
    input wire sys_clk,
    input wire wr_en,
    input wire [IDX_W-1:0] wr_idx,
    input wire [ADDR_W-1:0] wr_base,
    input wire [LEN_W-1:0] wr_len,
    input wire [IDX_W-1:0] rd_idx,
    output reg [ADDR_W-1:0] rd_base,
    output reg [LEN_W-1:0] rd_len
);

    reg [ADDR_W-1:0] base_mem [0:DEPTH-1];
    reg [LEN_W-1:0] len_mem [0:DEPTH-1];

    // write port; no reset, entries are only read once configured
    always @(posedge sys_clk) begin
        if (wr_en) begin
            base_mem[wr_idx] <= wr_base;
            len_mem[wr_idx] <= wr_len;
        end
    end

    // registered read port
    always @(posedge sys_clk) begin
        rd_base <= base_mem[rd_idx];
        rd_len <= len_mem[rd_idx];
    end

endmodule // queue_param_store

/* File: hdl/queue_config_command_reg.v */
/*
 * global command register of the dma engine: queue set-up on action
 * request, per-channel transmit descriptor re-poll, result vectors and
 * routing of interrupt vectors into the ten interrupt queues.
 * assumes all inputs come from logic on sys_clk; the queue base and
 * length registers, global status and global config live outside.
 */
`timescale 1ns/10ps
`include "queue_cmd_regs.vh"
module queue_config_command_reg #(
    parameter ADDR_W = 32,
    parameter LEN_W = 12,
    parameter CHANNELS = 4
) (
    input wire sys_clk,
    input wire rst_b,
    input wire cmd_wr_en,
    input wire [31:0] cmd_wr_data,
    output wire [31:0] cmd_rd_data,
    input wire hold_control_select,
    output wire qparam_req,
    output wire [3:0] qparam_idx,
    input wire qparam_ack,
    input wire [ADDR_W-1:0] qparam_base,
    input wire [LEN_W-1:0] qparam_len,
    output reg result_ack_set,
    output reg result_fail_set,
    output wire action_busy,
    output wire [9:0] queue_configured,
    input wire [CHANNELS-1:0] tx_on_hold,
    output wire [CHANNELS-1:0] desc_reread_req,
    input wire [CHANNELS-1:0] desc_reread_done,
    input wire [CHANNELS-1:0] desc_hold_flag,
    output reg [CHANNELS-1:0] tx_advance,
    input wire vec_valid,
    input wire [3:0] vec_src,
    input wire [31:0] vec_data,
    output wire vec_ready,
    output reg vq_wr_en,
    output reg [3:0] vq_wr_id,
    output reg [ADDR_W-1:0] vq_wr_addr,
    output reg [31:0] vq_wr_data,
    output reg vec_dropped
);

    // set-up engine states
    localparam [1:0] A_IDLE = 2'd0;
    localparam [1:0] A_SCAN = 2'd1;
    localparam [1:0] A_FETCH = 2'd2;
    localparam [1:0] A_DONE = 2'd3;
    // vector router states
    localparam R_IDLE = 1'b0;
    localparam R_LOOK = 1'b1;

    // lowest selected queue of a pending mask
    function [3:0] first_set;
        input [9:0] m;
        integer k;
        begin
            first_set = 4'd0;
            for (k = 9; k >= 0; k = k - 1) begin
                if (m[k]) begin
                    first_set = k[3:0];
                end
            end
        end
    endfunction

    // next write slot, wrapping at the programmed length
    function [LEN_W-1:0] wrap_inc;
        input [LEN_W-1:0] p;
        input [LEN_W-1:0] len;
        begin
            if (p + 1'b1 >= len) begin
                wrap_inc = {LEN_W{1'b0}};
            end else begin
                wrap_inc = p + 1'b1;
            end
        end
    endfunction

    reg [7:0] chan_setup_reg;
    reg cfg_setup_reg;
    reg per_setup_reg;
    reg mask_reg;
    reg action_reg;
    reg [1:0] a_state_reg;
    reg [9:0] pend_reg;
    reg [3:0] cur_idx_reg;
    reg fail_reg;
    reg snap_mask_reg;
    reg [9:0] configured_reg;
    reg cfg_vec_pend_reg;
    reg [31:0] cfg_vec_reg;
    reg [CHANNELS-1:0] reread_reg;
    reg r_state_reg;
    reg [3:0] r_id_reg;
    reg [31:0] r_data_reg;
    reg [LEN_W-1:0] wptr_reg [0:9];
    wire [ADDR_W-1:0] mem_base;
    wire [LEN_W-1:0] mem_len;
    wire mem_wr;
    wire [9:0] all_setup;
    wire take_cfg;
    wire take_ext;
    wire [3:0] look_idx;
    wire [CHANNELS-1:0] repoll_bits;
    integer i;
    // separate loop index so each variable has one writing process
    integer j;

    // unused positions are constant zero; repoll bits never stored
    assign cmd_rd_data = {chan_setup_reg, 2'b00, cfg_setup_reg, per_setup_reg,
                          4'h0, 2'b00, 4'h0, mask_reg, 8'h00, action_reg};

    // queue set order matches the queue numbering
    assign all_setup = {per_setup_reg, cfg_setup_reg, chan_setup_reg[3:0],
                        chan_setup_reg[7:4]};
    assign repoll_bits = cmd_wr_data[`GCMD_REPOLL_MSB:`GCMD_REPOLL_LSB];
    assign action_busy = (a_state_reg != A_IDLE) | action_reg;
    assign queue_configured = configured_reg;

    // command register writes; action bit kept until the engine takes it
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            chan_setup_reg <= 8'h00;
            cfg_setup_reg <= 1'b0;
            per_setup_reg <= 1'b0;
            mask_reg <= 1'b1; // reset value masks results
            action_reg <= 1'b0;
        end else begin
            if (cmd_wr_en) begin
                chan_setup_reg <= cmd_wr_data[`GCMD_RXQ_MSB:`GCMD_TXQ_LSB];
                cfg_setup_reg <= cmd_wr_data[`GCMD_CFGQ_BIT];
                per_setup_reg <= cmd_wr_data[`GCMD_PERQ_BIT];
                mask_reg <= cmd_wr_data[`GCMD_MASK_BIT];
            end
            // a new request written in the taking cycle is not lost
            if (cmd_wr_en && cmd_wr_data[`GCMD_ACTION_BIT]) begin
                action_reg <= 1'b1;
            end else if (a_state_reg == A_IDLE) begin
                action_reg <= 1'b0; // self-clearing once taken
            end
        end
    end

    // parameter fetch port, one queue at a time
    assign qparam_req = (a_state_reg == A_FETCH);
    assign qparam_idx = cur_idx_reg;
    assign mem_wr = (a_state_reg == A_FETCH) & qparam_ack;

    // set-up engine: snapshot, fetch each selected queue, then report
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            a_state_reg <= A_IDLE;
            pend_reg <= 10'h000;
            cur_idx_reg <= 4'h0;
            fail_reg <= 1'b0;
            snap_mask_reg <= 1'b1;
            configured_reg <= 10'h000;
            result_ack_set <= 1'b0;
            result_fail_set <= 1'b0;
        end else begin
            result_ack_set <= 1'b0;
            result_fail_set <= 1'b0;
            case (a_state_reg)
                A_IDLE: begin
                    if (action_reg) begin
                        // setup bits only matter with a request
                        pend_reg <= all_setup;
                        snap_mask_reg <= mask_reg;
                        fail_reg <= 1'b0;
                        a_state_reg <= A_SCAN;
                    end
                end
                A_SCAN: begin
                    if (pend_reg == 10'h000) begin
                        a_state_reg <= A_DONE; // all processes finished
                    end else begin
                        cur_idx_reg <= first_set(pend_reg);
                        a_state_reg <= A_FETCH;
                    end
                end
                A_FETCH: begin
                    // base trusted as programmed beforehand; only the length is checked
                    if (qparam_ack) begin
                        pend_reg[cur_idx_reg] <= 1'b0;
                        // zero length queue cannot hold a vector
                        if (qparam_len == {LEN_W{1'b0}}) begin
                            fail_reg <= 1'b1;
                            configured_reg[cur_idx_reg] <= 1'b0;
                        end else begin
                            configured_reg[cur_idx_reg] <= 1'b1;
                        end
                        a_state_reg <= A_SCAN;
                    end
                end
                A_DONE: begin
                    result_ack_set <= ~fail_reg;
                    result_fail_set <= fail_reg;
                    a_state_reg <= A_IDLE;
                end
                default: begin
                    a_state_reg <= A_IDLE;
                end
            endcase
        end
    end

    // result vector waits for the router; set beats clear
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_vec_pend_reg <= 1'b0;
            cfg_vec_reg <= 32'h0000_0000;
        end else if (a_state_reg == A_DONE && !snap_mask_reg) begin
            cfg_vec_pend_reg <= 1'b1;
            cfg_vec_reg <= fail_reg ? `VEC_ACTION_FAIL : `VEC_ACTION_ACK;
        end else if (take_cfg) begin
            cfg_vec_pend_reg <= 1'b0; // masked result never queued
        end
    end

    // transmit descriptor re-poll per channel
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            reread_reg <= {CHANNELS{1'b0}};
            tx_advance <= {CHANNELS{1'b0}};
        end else begin
            for (i = 0; i < CHANNELS; i = i + 1) begin
                tx_advance[i] <= 1'b0;
                if (reread_reg[i]) begin
                    if (desc_reread_done[i]) begin
                        reread_reg[i] <= 1'b0;
                        // still held: stays stopped, nothing issued
                        tx_advance[i] <= ~desc_hold_flag[i];
                    end
                end else if (cmd_wr_en && repoll_bits[i] && !hold_control_select
                             && tx_on_hold[i]) begin
                    reread_reg[i] <= 1'b1;
                end
                // otherwise the poll is simply dropped
            end
        end
    end

    assign desc_reread_req = reread_reg;

    // router: result vector first, then external sources
    assign take_cfg = (r_state_reg == R_IDLE) & cfg_vec_pend_reg;
    assign take_ext = (r_state_reg == R_IDLE) & ~cfg_vec_pend_reg & vec_valid;
    assign vec_ready = (r_state_reg == R_IDLE) & ~cfg_vec_pend_reg;
    // source ids 0..3 rx, 4..7 tx, 9 peripheral; config only internal
    assign look_idx = take_cfg ? `QID_CFG : vec_src;

    queue_param_store #(
        .DEPTH(`NUM_QUEUES),
        .IDX_W(4),
        .ADDR_W(ADDR_W),
        .LEN_W(LEN_W)
    ) u_store (
        .sys_clk(sys_clk),
        .wr_en(mem_wr),
        .wr_idx(cur_idx_reg),
        .wr_base(qparam_base),
        .wr_len(qparam_len),
        .rd_idx(look_idx),
        .rd_base(mem_base),
        .rd_len(mem_len)
    );

    // two-cycle lookup: capture vector, then form the queue address
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            r_state_reg <= R_IDLE;
            r_id_reg <= 4'h0;
            r_data_reg <= 32'h0000_0000;
            vq_wr_en <= 1'b0;
            vq_wr_id <= 4'h0;
            vq_wr_addr <= {ADDR_W{1'b0}};
            vq_wr_data <= 32'h0000_0000;
            vec_dropped <= 1'b0;
            for (j = 0; j < 10; j = j + 1) begin
                wptr_reg[j] <= {LEN_W{1'b0}};
            end
        end else begin
            vq_wr_en <= 1'b0;
            vec_dropped <= 1'b0;
            // a freshly configured queue restarts at its base
            if (mem_wr) begin
                wptr_reg[cur_idx_reg] <= {LEN_W{1'b0}};
            end
            case (r_state_reg)
                R_IDLE: begin
                    if (take_cfg || take_ext) begin
                        r_id_reg <= look_idx;
                        r_data_reg <= take_cfg ? cfg_vec_reg : vec_data;
                        r_state_reg <= R_LOOK;
                    end
                end
                R_LOOK: begin
                    r_state_reg <= R_IDLE;
                    // unconfigured or out-of-range target: vector lost
                    if (r_id_reg < `NUM_QUEUES && configured_reg[r_id_reg]
                        && !(mem_wr && cur_idx_reg == r_id_reg)) begin
                        vq_wr_en <= 1'b1;
                        vq_wr_id <= r_id_reg;
                        vq_wr_data <= r_data_reg;
                        vq_wr_addr <= mem_base
                            + {{(ADDR_W-LEN_W-2){1'b0}}, wptr_reg[r_id_reg], 2'b00};
                        wptr_reg[r_id_reg] <= wrap_inc(wptr_reg[r_id_reg], mem_len);
                    end else begin
                        vec_dropped <= 1'b1;
                    end
                end
                default: begin
                    r_state_reg <= R_IDLE;
                end
            endcase
        end
    end

endmodule // queue_config_command_reg

/* File: bench/queue_cmd_sva.sv */
/* checker for the global command register, bound into the block.
   assumes one clock, sys_clk, and a synchronous active-low reset. */
`timescale 1ns/10ps
module queue_cmd_sva #(parameter CHANNELS = 4) (
    input wire sys_clk,
    input wire rst_b,
    input wire cmd_wr_en,
    input wire [31:0] cmd_wr_data,
    input wire [31:0] cmd_rd_data,
    input wire hold_control_select,
    input wire qparam_req,
    input wire result_ack_set,
    input wire result_fail_set,
    input wire action_busy,
    input wire [CHANNELS-1:0] tx_on_hold,
    input wire [CHANNELS-1:0] desc_reread_req,
    input wire [CHANNELS-1:0] desc_reread_done,
    input wire [CHANNELS-1:0] desc_hold_flag,
    input wire [CHANNELS-1:0] tx_advance
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // reset check must run while reset is low, so it keeps no disable
    a_reset_value: assert property (disable iff (1'b0)
        !rst_b |=> cmd_rd_data == 32'h0000_0200) else $error("bad reset value");
    a_fixed_zero: assert property ((cmd_rd_data & 32'h00CF_FDFE) == 32'h0000_0000)
        else $error("fixed zero bit reads one");
    a_fields_stored: assert property (cmd_wr_en |=>
        (cmd_rd_data & 32'hFF30_0200) == ($past(cmd_wr_data) & 32'hFF30_0200))
        else $error("command fields not stored");
    a_single_result: assert property (!(result_ack_set && result_fail_set))
        else $error("ack and fail together");
    a_result_after_fetch: assert property ((result_ack_set || result_fail_set) |-> !qparam_req)
        else $error("result during fetch");
    a_request_ends: assert property ($rose(action_busy) |->
        ##[1:300] (result_ack_set || result_fail_set)) else $error("request never ends");
    a_action_clears: assert property (cmd_rd_data[0] |-> ##[1:300] !cmd_rd_data[0])
        else $error("action bit stuck");
    a_repoll_start: assert property (cmd_wr_en && cmd_wr_data[10] && !hold_control_select
        && tx_on_hold[0] && !desc_reread_req[0] |=> desc_reread_req[0])
        else $error("repoll not started");
    a_repoll_drop: assert property (cmd_wr_en && cmd_wr_data[10] && !desc_reread_req[0]
        && (hold_control_select || !tx_on_hold[0]) |=> !desc_reread_req[0])
        else $error("repoll not discarded");
    a_advance_cause: assert property (desc_reread_req[0] && desc_reread_done[0] |=>
        tx_advance[0] == !$past(desc_hold_flag[0])) else $error("wrong advance");
    a_held_stays: assert property (tx_advance[0] |->
        $past(desc_reread_done[0] && desc_reread_req[0])) else $error("advance without repoll");

    c_ack: cover property (result_ack_set);
    c_fail: cover property (result_fail_set);
    c_advance: cover property (tx_advance[0]);
endmodule // queue_cmd_sva

/* File: bench/queue_config_command_reg_tb.sv */
/* self-checking bench for the global command register.
   assumes the block and its header are compiled first; checker bound below. */
`timescale 1ns/10ps
`include "queue_cmd_regs.vh"
module queue_config_command_reg_tb;
    reg sys_clk = 0;
    reg rst_b = 0;
    reg cmd_wr_en = 0;
    reg [31:0] cmd_wr_data = 0;
    reg hold_control_select = 0;
    reg qparam_ack = 0;
    reg [31:0] qparam_base = 0;
    reg [11:0] qparam_len = 0;
    reg [3:0] tx_on_hold = 0, desc_reread_done = 0, desc_hold_flag = 0;
    reg vec_valid = 0;
    reg [3:0] vec_src = 0, last_idx = 0, fail_idx = 4'hF;
    reg [31:0] vec_data = 0;
    reg [9:0] fetched = 0;
    reg order_bad = 0;
    wire [31:0] cmd_rd_data, vq_wr_addr, vq_wr_data;
    wire qparam_req, result_ack_set, result_fail_set, action_busy, vec_ready, vq_wr_en, vec_dropped;
    wire [3:0] qparam_idx, desc_reread_req, tx_advance, vq_wr_id;
    wire [9:0] queue_configured;
    integer mismatches = 0, n_tests = 0, cycles = 0, n_wr = 0, n_drop = 0, n_ack = 0, n_fail = 0;

    queue_config_command_reg #(.ADDR_W(32), .LEN_W(12), .CHANNELS(4)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .cmd_wr_en(cmd_wr_en), .cmd_wr_data(cmd_wr_data),
        .cmd_rd_data(cmd_rd_data), .hold_control_select(hold_control_select),
        .qparam_req(qparam_req), .qparam_idx(qparam_idx), .qparam_ack(qparam_ack),
        .qparam_base(qparam_base), .qparam_len(qparam_len), .result_ack_set(result_ack_set),
        .result_fail_set(result_fail_set), .action_busy(action_busy),
        .queue_configured(queue_configured), .tx_on_hold(tx_on_hold),
        .desc_reread_req(desc_reread_req), .desc_reread_done(desc_reread_done),
        .desc_hold_flag(desc_hold_flag), .tx_advance(tx_advance), .vec_valid(vec_valid),
        .vec_src(vec_src), .vec_data(vec_data), .vec_ready(vec_ready), .vq_wr_en(vq_wr_en),
        .vq_wr_id(vq_wr_id), .vq_wr_addr(vq_wr_addr), .vq_wr_data(vq_wr_data),
        .vec_dropped(vec_dropped));

    initial forever #4 sys_clk = ~sys_clk;

    // queue parameter source: base from queue number, length zero only for fail_idx
    always @(posedge sys_clk) begin
        qparam_ack <= qparam_req && !qparam_ack;
        qparam_base <= 32'h1000_0000 + {qparam_idx, 8'h00};
        qparam_len <= (qparam_idx == fail_idx) ? 12'h000 : 12'h004;
        if (qparam_req && qparam_ack) begin
            order_bad <= order_bad | (fetched != 0 && qparam_idx <= last_idx);
            fetched[qparam_idx] <= 1'b1;
            last_idx <= qparam_idx;
        end
    end

    // pulse counters and hang guard; pulses last one cycle so count them here
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        // outputs are unknown before reset lands, which would poison the sums
        if (rst_b) begin
            n_wr <= n_wr + vq_wr_en;
            n_drop <= n_drop + vec_dropped;
            n_ack <= n_ack + result_ack_set;
            n_fail <= n_fail + result_fail_set;
        end
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end

    task check(input string what, input [31:0] exp, input [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input [31:0] d);
        @(posedge sys_clk);
        cmd_wr_en <= 1'b1;
        cmd_wr_data <= d;
        @(posedge sys_clk);
        cmd_wr_en <= 1'b0;
        #1;
    endtask

    // one action request; waits for its result pulse under a bound
    task run_act(input [31:0] c, input [3:0] bad, input [9:0] cfg, input fail);
        integer na, nf, i;
        fail_idx = bad;
        fetched = 0;
        order_bad = 0;
        na = n_ack;
        nf = n_fail;
        wr(c);
        i = 0;
        while (n_ack == na && n_fail == nf && i < 300) begin
            @(posedge sys_clk);
            i = i + 1;
        end
        check("fetched set", {c[20], c[21], c[27:24], c[31:28]}, fetched);
        check("fetch order", 0, order_bad);
        check("ack count", !fail, n_ack - na);
        check("fail count", fail, n_fail - nf);
        repeat (4) @(posedge sys_clk);
        #1;
        check("configured", cfg, queue_configured);
    endtask

    // offer one vector and judge where it lands
    task send(input [3:0] s);
        integer w, d, i;
        w = n_wr;
        d = n_drop;
        i = 0;
        @(posedge sys_clk);
        vec_valid <= 1'b1;
        vec_src <= s;
        vec_data <= 32'hC0DE_0000 + s;
        do begin
            @(posedge sys_clk);
            i = i + 1;
        end while (vec_ready !== 1'b1 && i < 20);
        vec_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check("drops", s == 0 || s > 9, n_drop - d);
        check("writes", s != 0 && s < 10, n_wr - w);
        if (s != 0 && s < 10) begin
            check("vec id", s, vq_wr_id);
            check("vec addr", 32'h1000_0000 + {s, 8'h00}, vq_wr_addr);
            check("vec data", 32'hC0DE_0000 + s, vq_wr_data);
        end
    endtask

    task t_fields;
        check("reset value", `GCMD_RESET, cmd_rd_data);
        wr(32'hFFFF_FFFE);
        check("fields", 32'hFF30_0200, cmd_rd_data);
        repeat (8) @(posedge sys_clk);
        #1;
        check("no action", 0, {fetched, queue_configured, action_busy});
        check("repoll idle", 0, desc_reread_req);
        wr(32'h0000_0000);
        check("cleared", 0, cmd_rd_data);
        $display("test fields done");
    endtask

    task t_actions;
        integer w;
        run_act(32'h0020_0001, 4'hF, 10'h100, 0);
        check("ack vector", `VEC_ACTION_ACK, vq_wr_data);
        check("ack queue", 32'h0000_0008, vq_wr_id);
        run_act(32'hFF30_0001, 4'hF, 10'h3FF, 0);
        check("ack addr", 32'h1000_0800, vq_wr_addr);
        run_act(32'h1000_0001, 4'h0, 10'h3FE, 1);
        check("fail vector", `VEC_ACTION_FAIL, vq_wr_data);
        check("fail addr", 32'h1000_0804, vq_wr_addr);
        w = n_wr;
        run_act(32'h0000_0201, 4'hF, 10'h3FE, 0);
        check("masked", w, n_wr);
        fetched = 0;
        wr(32'h0100_0000);
        repeat (10) @(posedge sys_clk);
        #1;
        check("no request", 0, {fetched, action_busy});
        $display("test actions done");
    endtask

    task t_vectors;
        integer s;
        // id 10 names no queue and must be dropped
        for (s = 0; s < 11; s = s + 1) begin
            if (s != 8) send(s[3:0]);
        end
        $display("test vectors done");
    endtask

    task t_repoll;
        @(posedge sys_clk);
        tx_on_hold <= 4'b0101;
        wr(32'h0000_3C00);
        check("reread", 4'b0101, desc_reread_req);
        check("repoll read", 0, cmd_rd_data & 32'h0000_3C00);
        repeat (3) @(posedge sys_clk);
        #1;
        check("held", 0, tx_advance);
        @(posedge sys_clk);
        desc_reread_done <= 4'b0101;
        desc_hold_flag <= 4'b0100;
        @(posedge sys_clk);
        desc_reread_done <= 4'b0000;
        #1;
        check("advance", 4'b0001, tx_advance);
        check("reread end", 0, desc_reread_req);
        @(posedge sys_clk);
        hold_control_select <= 1'b1;
        wr(32'h0000_3C00);
        check("mode off", 0, desc_reread_req);
        $display("test repoll done");
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_fields;
        t_actions;
        t_vectors;
        t_repoll;
        end_of_test;
    end
endmodule // queue_config_command_reg_tb

bind queue_config_command_reg queue_cmd_sva #(.CHANNELS(CHANNELS)) chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_wr_en(cmd_wr_en), .cmd_wr_data(cmd_wr_data),
    .cmd_rd_data(cmd_rd_data), .hold_control_select(hold_control_select),
    .qparam_req(qparam_req), .result_ack_set(result_ack_set),
    .result_fail_set(result_fail_set), .action_busy(action_busy), .tx_on_hold(tx_on_hold),
    .desc_reread_req(desc_reread_req), .desc_reread_done(desc_reread_done),
    .desc_hold_flag(desc_hold_flag), .tx_advance(tx_advance));
